// File: rtl/can_mbx_pkg.sv
// shared constants for the mailbox control and fifo control ends
package can_mbx_pkg;
    // ==================================================
    // register map (word index on the carrier)
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] REG_MCTL = 4'h0;
    localparam logic [3:0] REG_RFCR = 4'h1;
    localparam logic [3:0] REG_RFPCR = 4'h2;
    localparam logic [3:0] REG_TFCR = 4'h3;
    localparam logic [3:0] REG_TFPCR = 4'h4;
    localparam logic [3:0] REG_CHCTL = 4'h5;
    localparam logic [3:0] REG_HOST_STAT = 4'h8;
    localparam logic [7:0] PTR_ADV_KEY = 8'hFF;
    localparam logic [7:0] RD_NONE = 8'h00;
    // ==================================================
    // mailbox_msg_control fields
    localparam int MCTL_NEW = 0;
    localparam int MCTL_DONE = 1;
    localparam int MCTL_UPD = 2;
    localparam int MCTL_SHOT = 3;
    localparam int MCTL_LOST = 4;
    localparam int MCTL_ABT = 5;
    localparam int MCTL_RXRQ = 6;
    localparam int MCTL_TXRQ = 7;
    // ==================================================
    // fifo control fields
    localparam int RF_EN = 0;
    localparam int RF_CNT = 1;
    localparam int RF_LOST = 4;
    localparam int RF_FULL = 5;
    localparam int RF_WARN = 6;
    localparam int RF_EMPTY = 7;
    localparam int TF_EN = 0;
    localparam int TF_CNT = 1;
    localparam int TF_FULL = 6;
    localparam int TF_EMPTY = 7;
    localparam int CNT_W = 3;
    localparam int CH_FIFO_SEL = 0;
    localparam int CH_OVERWRITE = 1;
    localparam int HS_REFUSED = 0;
    // ==================================================
    // fifo levels and timing
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [2:0] CNT_WARN = 3'h3;
    localparam logic [2:0] CNT_FULL = 3'h4;
    localparam logic [2:0] LOST_GUARD_CYC = 3'h5;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_ACTIVE = 2'b10
    } tx_state_e;
endpackage

// File: rtl/can_mbx_if.sv
// carrier between the register-owning device end and the controlling end
`timescale 1ns/1ps
interface can_mbx_if;
    import can_mbx_pkg::*;
    logic wr;
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] mctl;
    logic [7:0] rfcr;
    logic [7:0] tfcr;
    logic [7:0] chctl;
    modport dev (input wr, input addr, input wdata, output mctl, output rfcr, output tfcr, output chctl);
    modport host (output wr, output addr, output wdata, input mctl, input rfcr, input tfcr, input chctl);
endinterface

// File: rtl/can_mbx_dev.sv
// mailbox message control plus receive and transmit fifo control, device end
`timescale 1ns/1ps
// Behaviour
// - abort request ends in abort or done flag
// - single-shot send: no retry, done or abort
// - success sets done only; abort cleared by 0
// - single-shot receive takes exactly one message
// - software clears single-shot only when settled
// - rx request clear ignored during frame acceptance
// - never rx and tx request together
// - tx to rx: abort, clear flags, then rx
// - cancelled tx ends in abort or done
// - rx to tx: abort, clear flags, then tx
// - rx fifo disable empties and zeroes count
// - no fifo enable in normal mailbox mode
// - rx fifo disable ignored during frame acceptance
// - full fifo loss flag, five-cycle clear guard
// - rx full at four, warning at three
// - rx empty when none held or disabled
// - FFh pops rx fifo; not while disabled
// - overwrite advances both pointers; loss blocks pop
// - tx fifo disable discards after current transfer
// - tx fifo re-enable only when empty
// - tx count unsent, zeroed after disable settles
// - tx full at four, empty at none
module can_mbx_dev
    import can_mbx_pkg::*;
(
    input logic clk_sys_i,
    input logic rst_n_i,
    can_mbx_if.dev bus,
    input logic crc_start_i,
    input logic filter_end_i,
    input logic mb_hit_i,
    input logic fifo_hit_i,
    input logic store_i,
    input logic bus_err_i,
    input logic eof6_i,
    input logic tx_start_i,
    input logic tx_from_fifo_i,
    input logic tx_ok_i,
    input logic arb_lost_i,
    input logic halt_i,
    output logic mb_rx_armed_o,
    output logic mb_tx_pending_o,
    output logic tx_fifo_pending_o,
    output logic [1:0] rx_fifo_slot_o,
    output logic [1:0] tx_fifo_slot_o
);
    // ==================================================
    // register writes
    function automatic logic clr0(input logic hit, input logic [7:0] d, input int b);
        return hit && !d[b];
    endfunction

    logic w_mctl;
    logic w_rfcr;
    logic w_tfcr;
    logic w_ch;
    logic w_rfpop;
    logic w_tfpush;
    assign w_mctl = bus.wr && bus.addr == REG_MCTL;
    assign w_rfcr = bus.wr && bus.addr == REG_RFCR;
    assign w_tfcr = bus.wr && bus.addr == REG_TFCR;
    assign w_ch = bus.wr && bus.addr == REG_CHCTL;
    assign w_rfpop = bus.wr && bus.addr == REG_RFPCR && bus.wdata == PTR_ADV_KEY;
    assign w_tfpush = bus.wr && bus.addr == REG_TFPCR && bus.wdata == PTR_ADV_KEY;

    logic fifo_sel;
    logic overwrite;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fifo_sel <= 1'b0;
            overwrite <= 1'b0;
        end
        else if (w_ch)
        begin
            fifo_sel <= bus.wdata[CH_FIFO_SEL];
            overwrite <= bus.wdata[CH_OVERWRITE];
        end
    end

    // ==================================================
    // mailbox receive side
    logic rx_request;
    logic tx_request;
    logic single_shot;
    logic new_msg_flag;
    logic update_in_progress;
    logic lost_msg_flag;
    logic mb_sel;
    logic mb_prot;
    logic mb_was_new;
    logic [2:0] mb_grd;
    logic mb_take;
    logic mb_lost_set;
    assign mb_take = filter_end_i && mb_hit_i && rx_request && !tx_request;
    // single-shot receive never reports overrun
    assign mb_lost_set = eof6_i && mb_sel && mb_was_new && !single_shot;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mb_sel <= 1'b0;
            mb_prot <= 1'b0;
            mb_was_new <= 1'b0;
        end
        else
        begin
            if (mb_take)
            begin
                mb_sel <= 1'b1;
                mb_was_new <= new_msg_flag;
            end
            else if (store_i || bus_err_i || crc_start_i)
                mb_sel <= 1'b0;
            if (crc_start_i)
                mb_prot <= 1'b1;
            else if ((filter_end_i && !mb_take) || store_i || bus_err_i)
                mb_prot <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_request <= 1'b0;
            tx_request <= 1'b0;
            single_shot <= 1'b0;
        end
        else
        begin
            if (store_i && mb_sel && single_shot)
                rx_request <= 1'b0;
            else if (w_mctl && (bus.wdata[MCTL_RXRQ] || !mb_prot))
                rx_request <= bus.wdata[MCTL_RXRQ];
            if (w_mctl)
            begin
                tx_request <= bus.wdata[MCTL_TXRQ];
                single_shot <= bus.wdata[MCTL_SHOT];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            new_msg_flag <= 1'b0;
            update_in_progress <= 1'b0;
            lost_msg_flag <= 1'b0;
            mb_grd <= CNT_ZERO;
        end
        else
        begin
            if (mb_take)
                update_in_progress <= 1'b1;
            else if (store_i || bus_err_i)
                update_in_progress <= 1'b0;
            // set beats a simultaneous clear; no clear while updating
            if (mb_take)
                new_msg_flag <= 1'b1;
            else if (clr0(w_mctl, bus.wdata, MCTL_NEW) && !update_in_progress)
                new_msg_flag <= 1'b0;
            if (mb_lost_set)
                mb_grd <= LOST_GUARD_CYC;
            else if (mb_grd != CNT_ZERO)
                mb_grd <= mb_grd - 3'h1;
            if (mb_lost_set)
                lost_msg_flag <= 1'b1;
            else if (clr0(w_mctl, bus.wdata, MCTL_LOST) && mb_grd == CNT_ZERO)
                lost_msg_flag <= 1'b0;
        end
    end

    // ==================================================
    // mailbox transmit side
    tx_state_e tx_state;
    logic tx_done_flag;
    logic abort_flag;
    logic mb_tx_ok;
    logic mb_tx_fail;
    logic give_up;
    logic mb_abort_set;
    assign mb_tx_ok = tx_state == TX_ACTIVE && tx_ok_i;
    assign mb_tx_fail = tx_state == TX_ACTIVE && !tx_ok_i && (arb_lost_i || bus_err_i);
    assign give_up = single_shot || !tx_request;
    assign mb_abort_set = (tx_state == TX_WAIT && !tx_request) || (mb_tx_fail && give_up);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tx_state <= TX_IDLE;
        else
        begin
            case (tx_state)
                TX_IDLE:
                    if (tx_request && !tx_done_flag && !abort_flag)
                        tx_state <= TX_WAIT;
                TX_WAIT:
                    if (!tx_request)
                        tx_state <= TX_IDLE;
                    else if (tx_start_i && !tx_from_fifo_i)
                        tx_state <= TX_ACTIVE;
                TX_ACTIVE:
                    if (mb_tx_ok)
                        tx_state <= TX_IDLE;
                    else if (mb_tx_fail)
                        tx_state <= give_up ? TX_IDLE : TX_WAIT;
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_done_flag <= 1'b0;
            abort_flag <= 1'b0;
        end
        else
        begin
            if (mb_tx_ok)
                tx_done_flag <= 1'b1;
            else if (clr0(w_mctl, bus.wdata, MCTL_DONE))
                tx_done_flag <= 1'b0;
            if (mb_abort_set)
                abort_flag <= 1'b1;
            else if (clr0(w_mctl, bus.wdata, MCTL_ABT))
                abort_flag <= 1'b0;
        end
    end

    // ==================================================
    // receive fifo
    logic rx_fifo_en;
    logic rx_fifo_lost;
    logic rf_sel;
    logic rf_prot;
    logic [1:0] rf_rptr;
    logic [2:0] rx_fifo_count;
    logic [2:0] rf_grd;
    logic rf_full;
    logic rf_push;
    logic rf_ovw;
    logic rf_pop;
    logic rf_take;
    logic rf_lost_set;
    assign rf_full = rx_fifo_count == CNT_FULL;
    assign rf_take = filter_end_i && fifo_hit_i && rx_fifo_en;
    assign rf_lost_set = eof6_i && rf_sel && rf_full;
    assign rf_push = store_i && rf_sel && !rf_full;
    assign rf_ovw = store_i && rf_sel && rf_full && overwrite;
    // a pending loss in overwrite mode blocks software pops; an overwrite still advances the read pointer
    assign rf_pop = w_rfpop && rx_fifo_en && rx_fifo_count != CNT_ZERO
        && !(overwrite && rx_fifo_lost);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_fifo_en <= 1'b0;
            rf_sel <= 1'b0;
            rf_prot <= 1'b0;
        end
        else
        begin
            if (w_rfcr && (bus.wdata[RF_EN] || !rf_prot))
                rx_fifo_en <= bus.wdata[RF_EN];
            if (rf_take)
                rf_sel <= 1'b1;
            else if (store_i || bus_err_i || crc_start_i)
                rf_sel <= 1'b0;
            if (crc_start_i && rx_fifo_en)
                rf_prot <= 1'b1;
            else if ((filter_end_i && !rf_take) || store_i || bus_err_i)
                rf_prot <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_fifo_slot_o <= 2'b00;
            rf_rptr <= 2'b00;
            rx_fifo_count <= CNT_ZERO;
        end
        else if (!rx_fifo_en)
        begin
            rx_fifo_slot_o <= 2'b00;
            rf_rptr <= 2'b00;
            rx_fifo_count <= CNT_ZERO;
        end
        else
        begin
            rx_fifo_slot_o <= rx_fifo_slot_o + {1'b0, rf_push | rf_ovw};
            rf_rptr <= rf_rptr + {1'b0, rf_ovw} + {1'b0, rf_pop};
            rx_fifo_count <= rx_fifo_count + {2'b00, rf_push} - {2'b00, rf_pop};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_fifo_lost <= 1'b0;
            rf_grd <= CNT_ZERO;
        end
        else
        begin
            if (rf_lost_set)
                rf_grd <= LOST_GUARD_CYC;
            else if (rf_grd != CNT_ZERO)
                rf_grd <= rf_grd - 3'h1;
            if (rf_lost_set)
                rx_fifo_lost <= 1'b1;
            else if (clr0(w_rfcr, bus.wdata, RF_LOST) && rf_grd == CNT_ZERO)
                rx_fifo_lost <= 1'b0;
        end
    end

    // ==================================================
    // transmit fifo
    logic tx_fifo_en;
    logic tf_busy;
    logic [1:0] tf_wptr;
    logic [2:0] tx_fifo_count;
    logic tf_push;
    logic tf_pop;
    logic tf_end;
    assign tf_push = w_tfpush && tx_fifo_en && tx_fifo_count != CNT_FULL;
    assign tf_pop = tf_busy && tx_ok_i;
    assign tf_end = tf_busy && (tx_ok_i || bus_err_i || arb_lost_i || halt_i);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_fifo_en <= 1'b0;
            tf_busy <= 1'b0;
        end
        else
        begin
            if (w_tfcr)
                tx_fifo_en <= bus.wdata[TF_EN];
            if (tx_start_i && tx_from_fifo_i && tx_fifo_pending_o)
                tf_busy <= 1'b1;
            else if (tf_end)
                tf_busy <= 1'b0;
        end
    end

    // a disabled fifo drains only once the frame on the wire has ended
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tf_wptr <= 2'b00;
            tx_fifo_slot_o <= 2'b00;
            tx_fifo_count <= CNT_ZERO;
        end
        else if (!tx_fifo_en && !tf_busy)
        begin
            tf_wptr <= 2'b00;
            tx_fifo_slot_o <= 2'b00;
            tx_fifo_count <= CNT_ZERO;
        end
        else
        begin
            tf_wptr <= tf_wptr + {1'b0, tf_push};
            tx_fifo_slot_o <= tx_fifo_slot_o + {1'b0, tf_pop};
            tx_fifo_count <= tx_fifo_count + {2'b00, tf_push} - {2'b00, tf_pop};
        end
    end

    // ==================================================
    // status mirrors and engine requests
    logic [7:0] next_mctl;
    logic [7:0] next_rfcr;
    logic [7:0] next_tfcr;
    always_comb
    begin
        next_mctl = RD_NONE;
        next_mctl[MCTL_NEW] = new_msg_flag;
        next_mctl[MCTL_DONE] = tx_done_flag;
        next_mctl[MCTL_UPD] = update_in_progress;
        next_mctl[MCTL_SHOT] = single_shot;
        next_mctl[MCTL_LOST] = lost_msg_flag;
        next_mctl[MCTL_ABT] = abort_flag;
        next_mctl[MCTL_RXRQ] = rx_request;
        next_mctl[MCTL_TXRQ] = tx_request;
        next_rfcr = RD_NONE;
        next_rfcr[RF_EN] = rx_fifo_en;
        // count reads zero from the disabling edge, one edge before the counter clears
        next_rfcr[RF_CNT +: CNT_W] = rx_fifo_en ? rx_fifo_count : CNT_ZERO;
        next_rfcr[RF_LOST] = rx_fifo_lost;
        next_rfcr[RF_FULL] = rx_fifo_en && rf_full;
        next_rfcr[RF_WARN] = rx_fifo_en && rx_fifo_count == CNT_WARN;
        next_rfcr[RF_EMPTY] = !rx_fifo_en || rx_fifo_count == CNT_ZERO;
        next_tfcr = RD_NONE;
        next_tfcr[TF_EN] = tx_fifo_en;
        next_tfcr[TF_CNT +: CNT_W] = tx_fifo_count;
        next_tfcr[TF_FULL] = tx_fifo_count == CNT_FULL;
        next_tfcr[TF_EMPTY] = tx_fifo_count == CNT_ZERO;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus.mctl <= RD_NONE;
            bus.rfcr <= RD_NONE;
            bus.tfcr <= RD_NONE;
            bus.chctl <= RD_NONE;
            mb_rx_armed_o <= 1'b0;
            mb_tx_pending_o <= 1'b0;
            tx_fifo_pending_o <= 1'b0;
        end
        else
        begin
            bus.mctl <= next_mctl;
            bus.rfcr <= next_rfcr;
            bus.tfcr <= next_tfcr;
            bus.chctl <= {6'h00, overwrite, fifo_sel};
            mb_rx_armed_o <= rx_request && !tx_request;
            mb_tx_pending_o <= tx_state == TX_WAIT && tx_request;
            tx_fifo_pending_o <= tx_fifo_en && tx_fifo_count != CNT_ZERO && !tf_busy;
        end
    end
endmodule

// File: rtl/can_mbx_host.sv
// controlling end: software port in, guarded register writes out
`timescale 1ns/1ps
module can_mbx_host
    import can_mbx_pkg::*;
(
    input logic clk_sys_i,
    input logic rst_n_i,
    can_mbx_if.host bus,
    input logic [REG_ADDR_W-1:0] addr_i,
    input logic [7:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [7:0] rdata_o
);
    // ==================================================
    // write guard
    logic [7:0] mc;
    logic [7:0] w;
    logic ok;
    assign mc = bus.mctl;
    assign w = wdata_i;

    always_comb
    begin
        ok = 1'b1;
        case (addr_i)
            REG_MCTL:
                ok = !(w[MCTL_RXRQ] && w[MCTL_TXRQ])
                    && !(w[MCTL_RXRQ] && !mc[MCTL_RXRQ] && (mc[MCTL_TXRQ] || mc[MCTL_DONE] || mc[MCTL_ABT]))
                    && !(w[MCTL_TXRQ] && !mc[MCTL_TXRQ] && (mc[MCTL_RXRQ] || mc[MCTL_NEW] || mc[MCTL_LOST]))
                    && !(!w[MCTL_SHOT] && mc[MCTL_SHOT] && (mc[MCTL_RXRQ]
                        || (mc[MCTL_TXRQ] && !mc[MCTL_DONE] && !mc[MCTL_ABT])));
            REG_RFCR:
                ok = !(w[RF_EN] && !bus.chctl[CH_FIFO_SEL]);
            REG_TFCR:
                ok = !(w[TF_EN] && !bus.chctl[CH_FIFO_SEL])
                    && !(w[TF_EN] && !bus.tfcr[TF_EN] && !bus.tfcr[TF_EMPTY]);
            REG_RFPCR:
                ok = bus.rfcr[RF_EN];
            REG_TFPCR:
                ok = bus.tfcr[TF_EN];
            REG_CHCTL:
                ok = w[CH_FIFO_SEL] || !(bus.rfcr[RF_EN] || bus.tfcr[TF_EN]);
            default:
                ok = 1'b1;
        endcase
    end

    // ==================================================
    // forwarding and own status
    logic refused;
    logic dev_addr;
    logic refuse_now;
    assign dev_addr = addr_i == REG_MCTL || addr_i == REG_RFCR || addr_i == REG_RFPCR
        || addr_i == REG_TFCR || addr_i == REG_TFPCR || addr_i == REG_CHCTL;
    assign refuse_now = wr_i && dev_addr && !ok;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus.wr <= 1'b0;
            bus.addr <= REG_MCTL;
            bus.wdata <= RD_NONE;
        end
        else
        begin
            bus.wr <= wr_i && dev_addr && ok;
            bus.addr <= addr_i;
            bus.wdata <= wdata_i;
        end
    end

    // a refusal in the same cycle as a clearing write keeps the flag
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            refused <= 1'b0;
        else if (refuse_now)
            refused <= 1'b1;
        else if (wr_i && addr_i == REG_HOST_STAT && !wdata_i[HS_REFUSED])
            refused <= 1'b0;
    end

    // answers come from mirrors, so they trail a forwarded write by two cycles
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= RD_NONE;
        else if (rd_i)
        begin
            case (addr_i)
                REG_MCTL: rdata_o <= bus.mctl;
                REG_RFCR: rdata_o <= bus.rfcr;
                REG_TFCR: rdata_o <= bus.tfcr;
                REG_CHCTL: rdata_o <= bus.chctl;
                REG_HOST_STAT: rdata_o <= {7'h00, refused};
                default: rdata_o <= RD_NONE;
            endcase
        end
        else
            rdata_o <= RD_NONE;
    end
endmodule

// File: verification/can_mbx_chk.sv
// concurrent checks on the carrier between both ends
`timescale 1ns/1ps
module can_mbx_chk
    import can_mbx_pkg::*;
(
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic wr,
    input logic [REG_ADDR_W-1:0] addr,
    input logic [7:0] mctl,
    input logic [7:0] rfcr,
    input logic [7:0] tfcr
);
    // ==================================================
    // helpers
    logic [1:0] up;
    logic [2:0] rc;
    logic [2:0] tc;
    assign rc = rfcr[3:1];
    assign tc = tfcr[3:1];
    // mirrors only settle one edge after reset release
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            up <= 2'h0;
        else
            up <= {up[0], 1'b1};
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ==================================================
    // assertions
    sequence s_tx_cancel;
        // a request dropped with a flag already up has nothing left to report
        (mctl[MCTL_TXRQ] && !mctl[MCTL_DONE] && !mctl[MCTL_ABT])
            ##1 (!mctl[MCTL_TXRQ] && !mctl[MCTL_DONE] && !mctl[MCTL_ABT]);
    endsequence
    a_cancel_settles: assert property (s_tx_cancel |-> ##[0:300] (mctl[MCTL_DONE] || mctl[MCTL_ABT]))
        else $error("cancel left no flag");
    a_done_no_abort: assert property ($rose(mctl[MCTL_DONE]) |-> !$rose(mctl[MCTL_ABT]))
        else $error("abort beside done");
    a_rx_full_flag: assert property (up[1] |-> rfcr[RF_FULL] == (rc == CNT_FULL))
        else $error("rx full flag wrong");
    a_rx_warn_flag: assert property (up[1] |-> rfcr[RF_WARN] == (rc == CNT_WARN))
        else $error("rx warn flag wrong");
    a_rx_empty_flag: assert property (up[1] |-> rfcr[RF_EMPTY] == (rc == CNT_ZERO))
        else $error("rx empty flag wrong");
    a_rx_off_zero: assert property (up[1] && !rfcr[RF_EN] |-> rc == CNT_ZERO)
        else $error("count kept while off");
    a_tx_full_flag: assert property (up[1] |-> tfcr[TF_FULL] |-> tc == CNT_FULL)
        else $error("tx full flag wrong");
    a_pop_when_on: assert property (wr && addr == REG_RFPCR |-> $past(rfcr[RF_EN]))
        else $error("pop sent while off");
endmodule

// File: verification/testbench.sv
// self-checking bench for both carrier ends
`timescale 1ns/1ps
module testbench;
    import can_mbx_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic armed;
    logic fpend;
    // engine pulses and levels
    logic [8:0] ev = 9'h000;
    logic [2:0] lv = 3'h0;
    int error_cnt = 0;
    int n_tests = 0;
    can_mbx_if bus_if();
    can_mbx_host can_mbx_host_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus_if), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    can_mbx_dev can_mbx_dev_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus_if), .crc_start_i(ev[0]),
        .filter_end_i(ev[1]), .mb_hit_i(lv[0]), .fifo_hit_i(lv[1]), .store_i(ev[2]), .bus_err_i(ev[3]),
        .eof6_i(ev[4]), .tx_start_i(ev[5]), .tx_from_fifo_i(lv[2]), .tx_ok_i(ev[6]), .arb_lost_i(ev[7]),
        .halt_i(ev[8]), .mb_rx_armed_o(armed), .mb_tx_pending_o(), .tx_fifo_pending_o(fpend), .rx_fifo_slot_o(),
        .tx_fifo_slot_o());
    can_mbx_chk can_mbx_chk_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr(bus_if.wr), .addr(bus_if.addr),
        .mctl(bus_if.mctl), .rfcr(bus_if.rfcr), .tfcr(bus_if.tfcr));
    // ==================================================
    // bus and event tasks
    // guards read mirrors two cycles late, so writes are spaced
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        n_tests++;
        if ((rdata_o & m) !== e)
            $display("BAD reg %h exp %h got %h", a, e, rdata_o & m);
        if ((rdata_o & m) !== e)
            error_cnt++;
    endtask
    // only called right after chk, so the flops have settled
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic p(input logic [8:0] m);
        @(posedge clk_sys_i);
        ev <= m;
        @(posedge clk_sys_i);
        ev <= 9'h000;
    endtask
    task automatic msg;
        p(9'h001);
        p(9'h002);
        p(9'h004);
    endtask
    function automatic logic [7:0] rf(input logic [2:0] c, input logic l);
        return {c == 3'h0, c == 3'h3, c == 3'h4, l, c, 1'b1};
    endfunction
    // ==================================================
    // scenarios
    task automatic tx_case;
        w(REG_MCTL, 8'h80);
        w(REG_MCTL, 8'h00);
        chk(REG_MCTL, 8'hA2, 8'h20);
        w(REG_MCTL, 8'h00);
        w(REG_MCTL, 8'h88);
        p(9'h020);
        p(9'h080);
        chk(REG_MCTL, 8'h22, 8'h20);
        w(REG_MCTL, 8'h00);
        w(REG_MCTL, 8'h80);
        p(9'h020);
        p(9'h080);
        chk(REG_MCTL, 8'h22, 8'h00);
        p(9'h020);
        p(9'h040);
        chk(REG_MCTL, 8'h22, 8'h02);
        // request and done drop together in the first write
        repeat (3) w(REG_MCTL, 8'h00);
        chk(REG_MCTL, 8'hFF, 8'h00);
    endtask
    task automatic rx_shot_case;
        @(posedge clk_sys_i);
        lv <= 3'h1;
        w(REG_MCTL, 8'h40);
        p(9'h001);
        w(REG_MCTL, 8'h00);
        p(9'h002);
        p(9'h004);
        chk(REG_MCTL, 8'h41, 8'h41);
        w(REG_MCTL, 8'h00);
        w(REG_MCTL, 8'h48);
        chk(REG_MCTL, 8'hC8, 8'h48);
        cmp("rx armed", 8'h01, {7'h00, armed});
        msg();
        chk(REG_MCTL, 8'h55, 8'h01);
        cmp("rx armed", 8'h00, {7'h00, armed});
        msg();
        p(9'h010);
        chk(REG_MCTL, 8'h55, 8'h01);
    endtask
    task automatic rx_fifo_case;
        @(posedge clk_sys_i);
        lv <= 3'h2;
        w(REG_CHCTL, 8'h01);
        w(REG_RFCR, 8'h01);
        p(9'h001);
        w(REG_RFCR, 8'h00);
        p(9'h002);
        p(9'h004);
        chk(REG_RFCR, 8'hFF, rf(3'h1, 1'b0));
        for (int i = 2; i <= 4; i++)
        begin
            msg();
            chk(REG_RFCR, 8'hFF, rf(3'(i), 1'b0));
        end
        // overrun message: loss is flagged at eof6, before the store slot
        p(9'h001);
        p(9'h002);
        p(9'h010);
        p(9'h004);
        w(REG_RFCR, 8'h01);
        chk(REG_RFCR, 8'hFF, rf(3'h4, 1'b1));
        w(REG_RFCR, 8'h01);
        chk(REG_RFCR, 8'hFF, rf(3'h4, 1'b0));
        w(REG_RFPCR, PTR_ADV_KEY);
        chk(REG_RFCR, 8'hFF, rf(3'h3, 1'b0));
        w(REG_RFCR, 8'h00);
        chk(REG_RFCR, 8'hFF, 8'h80);
        w(REG_RFPCR, PTR_ADV_KEY);
        chk(REG_HOST_STAT, 8'h01, 8'h01);
    endtask
    task automatic tx_fifo_case;
        @(posedge clk_sys_i);
        lv <= 3'h4;
        w(REG_TFCR, 8'h01);
        repeat (4) w(REG_TFPCR, PTR_ADV_KEY);
        chk(REG_TFCR, 8'hFF, 8'h49);
        cmp("tx fifo pending", 8'h01, {7'h00, fpend});
        p(9'h020);
        w(REG_TFCR, 8'h00);
        chk(REG_TFCR, 8'hFF, 8'h48);
        cmp("tx fifo pending", 8'h00, {7'h00, fpend});
        p(9'h040);
        // count drops by one, then clears, then reaches the mirror
        repeat (2) @(posedge clk_sys_i);
        chk(REG_TFCR, 8'hFF, 8'h80);
    endtask
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==================================================
    // clock, watchdog, main sequence
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        results();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        tx_case();
        rx_shot_case();
        rx_fifo_case();
        tx_fifo_case();
        results();
    end
endmodule
